/* File: core/video_encoder_control_regs.sv */
// control register bank of the video encoder behind the two-wire serial bus
module video_encoder_control_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // two-wire serial bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // video standard and pixel input
  input wire logic pal_mode,
  input wire logic [15:0] pixel_in,
  output logic [15:0] pixel_data,
  // timing controls
  output enc_ctrl_pkg::sync_cfg_t sync_cfg,
  output logic long_vsync_select,
  output logic [2:0] vsync_half_lines,
  output logic timing_counter_reset,
  output logic [3:0] luma_delay_cycles,
  // output shaping and power
  output logic pedestal_on,
  output logic blank_filter_on,
  output logic sleep,
  // subcarrier
  output logic [31:0] subcarrier_increment,
  output logic [7:0] subcarrier_phase,
  // caption and line data
  output logic [15:0] even_caption_data,
  output logic [15:0] odd_caption_data,
  output enc_ctrl_pkg::line_masks_t line_masks
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // mapped subaddresses answer; all others read zero and drop writes
  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == enc_ctrl_pkg::SUB_POWER) ||
             (a >= enc_ctrl_pkg::SUB_TIMING && a <= enc_ctrl_pkg::SUB_LAST);
  endfunction : mapped

  function automatic logic [7:0] reset_value(input logic [4:0] a);
    reset_value = (a == enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_0) ? enc_ctrl_pkg::RST_SUBCARRIER_FREQ_BYTE_0
                                                 : enc_ctrl_pkg::RST_DEFAULT;
  endfunction : reset_value

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus events

  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  // two flops on each bus pin, then one more stage for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // serial bus engine

  enc_ctrl_pkg::bus_state_t st_r, st_nxt, after_r, after_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic [4:0] sub_r, sub_nxt;
  logic oe_r, oe_nxt;
  logic rw_r, rw_nxt;
  logic nack_r, nack_nxt;
  logic [7:0] rd_byte;

  // a byte is complete on the falling clock after its eighth bit
  wire byte_done = scl_fall && (cnt_r == 4'h8);
  // registers work in sleep as well, nothing here looks at sleep
  wire wr_stb = byte_done && (st_r == enc_ctrl_pkg::ST_WDATA);

  // next state of the bus engine
  always_comb begin
    st_nxt = st_r;
    after_nxt = after_r;
    cnt_nxt = cnt_r;
    shreg_nxt = shreg_r;
    sub_nxt = sub_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    if (bus_start) begin
      st_nxt = enc_ctrl_pkg::ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (bus_stop) begin
      st_nxt = enc_ctrl_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        enc_ctrl_pkg::ST_ADDR, enc_ctrl_pkg::ST_SUB, enc_ctrl_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shreg_nxt = {shreg_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_nxt = 4'h0;
            oe_nxt = 1'b1;
            st_nxt = enc_ctrl_pkg::ST_ACK;
            after_nxt = enc_ctrl_pkg::ST_WDATA;
            if (st_r == enc_ctrl_pkg::ST_ADDR) begin
              rw_nxt = shreg_r[0];
              after_nxt = shreg_r[0] ? enc_ctrl_pkg::ST_TX : enc_ctrl_pkg::ST_SUB;
              if (shreg_r[7:1] != DEV_ADDR) begin
                oe_nxt = 1'b0;
                st_nxt = enc_ctrl_pkg::ST_IDLE;
              end
            end else if (st_r == enc_ctrl_pkg::ST_SUB) begin
              sub_nxt = shreg_r[4:0];
            end else begin
              sub_nxt = sub_r + 5'h01;
            end
          end
        end
        enc_ctrl_pkg::ST_ACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            st_nxt = after_r;
            if (after_r == enc_ctrl_pkg::ST_TX) begin
              shreg_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              sub_nxt = sub_r + 5'h01;
            end
          end
        end
        enc_ctrl_pkg::ST_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            st_nxt = enc_ctrl_pkg::ST_MACK;
          end else if (scl_fall) begin
            oe_nxt = ~shreg_r[3'h7 - cnt_r[2:0]];
          end
        end
        enc_ctrl_pkg::ST_MACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            if (nack_r) begin
              st_nxt = enc_ctrl_pkg::ST_IDLE;
            end else begin
              st_nxt = enc_ctrl_pkg::ST_TX;
              shreg_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              sub_nxt = sub_r + 5'h01;
            end
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // bus engine flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= enc_ctrl_pkg::ST_IDLE;
      after_r <= enc_ctrl_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      sub_r <= 5'h00;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      after_r <= after_nxt;
      cnt_r <= cnt_nxt;
      shreg_r <= shreg_nxt;
      sub_r <= sub_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] regs_r [0:31];
  logic [7:0] tim_prev_r;
  logic tcr_r;

  // write port; unmapped subaddresses keep their reset zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        regs_r[i] <= reset_value(5'(i));
      end
    end else if (wr_stb && mapped(sub_r)) begin
      regs_r[sub_r] <= shreg_r;
    end
  end

  // reserved top bit of the power register always reads zero
  wire [7:0] rd_raw = mapped(sub_r) ? regs_r[sub_r] : 8'h00;
  assign rd_byte = (sub_r == enc_ctrl_pkg::SUB_POWER) ? {1'b0, rd_raw[6:0]} : rd_raw;

  // counter reset fires when a written 0 follows a stored 1
  wire tim_wr = wr_stb && (sub_r == enc_ctrl_pkg::SUB_TIMING);
  wire tcr_fire = tim_wr && !shreg_r[enc_ctrl_pkg::TRESET_BIT] &&
                  regs_r[enc_ctrl_pkg::SUB_TIMING][enc_ctrl_pkg::TRESET_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tcr_r <= 1'b0;
    end else begin
      tcr_r <= tcr_fire;
    end
  end

  assign timing_counter_reset = tcr_r;

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  wire [7:0] pwr = regs_r[enc_ctrl_pkg::SUB_POWER];
  wire [7:0] tim = regs_r[enc_ctrl_pkg::SUB_TIMING];
  wire [7:0] shp = regs_r[enc_ctrl_pkg::SUB_SYNC];
  wire [1:0] tmode = tim[enc_ctrl_pkg::MODE_LSB +: 2];
  wire [1:0] luma_field = tim[enc_ctrl_pkg::LUMA_LSB +: 2];
  wire port_wide = tim[enc_ctrl_pkg::PORT_BIT];

  assign sync_cfg.master = tim[enc_ctrl_pkg::MASTER_BIT];
  assign sync_cfg.timing_mode = tmode;
  // blank input honoured only in slave operation
  assign sync_cfg.blank_use = tim[enc_ctrl_pkg::BLANK_BIT] & ~tim[enc_ctrl_pkg::MASTER_BIT];
  assign sync_cfg.hsync_width = shp[1:0];
  assign sync_cfg.hsync_to_vsync_offset = shp[3:2];
  // shared field: meaning depends on timing mode
  assign sync_cfg.field_edge_offset = (tmode == enc_ctrl_pkg::TMODE_1) ? shp[5:4] : 2'h0;
  assign sync_cfg.vsync_width = (tmode == enc_ctrl_pkg::TMODE_2) ? shp[5:4] : 2'h0;
  assign sync_cfg.hsync_pixel_align = shp[7:6];

  // same length governs the driven output and the accepted input
  assign long_vsync_select = pwr[enc_ctrl_pkg::LONG_VSYNC_BIT];
  assign vsync_half_lines = !long_vsync_select ? 3'h0 :
                            pal_mode ? enc_ctrl_pkg::VS_HALF_PAL
                                     : enc_ctrl_pkg::VS_HALF_NTSC;

  assign pedestal_on = pwr[enc_ctrl_pkg::PEDESTAL_BIT] & ~pal_mode;
  assign blank_filter_on = pwr[enc_ctrl_pkg::FILTER_BIT];
  assign sleep = pwr[enc_ctrl_pkg::SLEEP_BIT];
  assign luma_delay_cycles = 4'(luma_field * enc_ctrl_pkg::LUMA_STEP_CYC);

  // caption bytes: low byte at the lower subaddress
  assign even_caption_data = {regs_r[enc_ctrl_pkg::SUB_CAPE0 + 5'h01],
                              regs_r[enc_ctrl_pkg::SUB_CAPE0]};
  assign odd_caption_data = {regs_r[enc_ctrl_pkg::SUB_CAPO0 + 5'h01],
                             regs_r[enc_ctrl_pkg::SUB_CAPO0]};

  // line bits mean pedestal off in NTSC and teletext on in PAL
  wire [15:0] even_lines = {regs_r[enc_ctrl_pkg::SUB_LINE0 + 5'h01],
                            regs_r[enc_ctrl_pkg::SUB_LINE0]};
  wire [15:0] odd_lines = {regs_r[enc_ctrl_pkg::SUB_LAST],
                           regs_r[enc_ctrl_pkg::SUB_LAST - 5'h01]};
  assign line_masks.even_pedestal_line_mask = pal_mode ? 16'h0000 : even_lines;
  assign line_masks.odd_pedestal_line_mask = pal_mode ? 16'h0000 : odd_lines;
  assign line_masks.even_teletext_line_mask = pal_mode ? even_lines : 16'h0000;
  assign line_masks.odd_teletext_line_mask = pal_mode ? odd_lines : 16'h0000;

  // increment bytes assembled least significant first
  assign subcarrier_increment = {regs_r[enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_3],
                                 regs_r[enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_3 - 5'h01],
                                 regs_r[enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_0 + 5'h01],
                                 regs_r[enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_0]};

  ////////////////////////////////////////////////////////////////////////////
  // subcarrier accumulator and pixel port

  logic [31:0] acc_r;
  logic [7:0] phase_r;
  logic [15:0] pix_r;

  // accumulator halts in sleep and restarts on a counter reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= 32'h0000_0000;
    end else if (tcr_r) begin
      acc_r <= 32'h0000_0000;
    end else if (!sleep) begin
      acc_r <= acc_r + subcarrier_increment;
    end
  end

  // phase offset added to the accumulator top byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 8'h00;
    end else begin
      phase_r <= acc_r[31:24] + regs_r[enc_ctrl_pkg::SUB_PHASE];
    end
  end

  // narrow port takes only the low eight pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_r <= 16'h0000;
    end else begin
      pix_r <= port_wide ? pixel_in : {8'h00, pixel_in[7:0]};
    end
  end

  assign subcarrier_phase = phase_r;
  assign pixel_data = pix_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sleep_entry: assert property (
    wr_stb && sub_r == enc_ctrl_pkg::SUB_POWER && shreg_r[6] |=> sleep)
    else $error("sleep not entered after write of one");
  a_sleep_exit: assert property (
    wr_stb && sub_r == enc_ctrl_pkg::SUB_POWER && !shreg_r[6] |=> !sleep)
    else $error("sleep not left after write of zero");
  a_pedestal_pal_off: assert property (
    pal_mode |-> !pedestal_on && line_masks.even_pedestal_line_mask == 16'h0000)
    else $error("pedestal active in pal");
  a_vsync_ntsc_len: assert property (
    long_vsync_select && !pal_mode |-> vsync_half_lines == 3'h6)
    else $error("ntsc long vsync not three lines");
  a_vsync_pal_len: assert property (
    long_vsync_select && pal_mode |-> vsync_half_lines == 3'h5)
    else $error("pal long vsync not two and a half lines");
  a_treset_cause: assert property (
    $rose(timing_counter_reset) |-> $past(tim_wr) && $fell(tim[7]) ##1 !timing_counter_reset)
    else $error("timing reset pulse without falling bit");
  a_fsc_msb_order: assert property (
    wr_stb && sub_r == enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_3 |=> subcarrier_increment[31:24] == $past(shreg_r))
    else $error("top subcarrier byte misplaced");
  a_pixel_narrow: assert property (
    !port_wide ##1 !port_wide |-> pixel_data[15:8] == 8'h00)
    else $error("upper pixel byte passed in narrow mode");
  a_blank_slave_only: assert property (
    sync_cfg.blank_use |-> !sync_cfg.master)
    else $error("blank input used in master mode");
  a_shared_field: assert property (
    tmode != enc_ctrl_pkg::TMODE_2 |-> sync_cfg.vsync_width == 2'h0)
    else $error("vsync width outside timing mode two");
  a_accum_step: assert property (
    !sleep && !tcr_r ##1 1'b1 |-> acc_r == $past(acc_r) + $past(subcarrier_increment))
    else $error("accumulator did not advance by increment");
  a_reserved_read: assert property (
    sub_r == enc_ctrl_pkg::SUB_POWER |-> !rd_byte[7])
    else $error("reserved bit read as one");

  c_sleep_seen: cover property (sleep ##1 !sleep);
  c_treset_seen: cover property (timing_counter_reset);
  c_read_byte: cover property (rw_r && st_r == enc_ctrl_pkg::ST_MACK ##1
                               st_r == enc_ctrl_pkg::ST_TX);
  c_teletext_line: cover property (line_masks.odd_teletext_line_mask != 16'h0000);

endmodule : video_encoder_control_regs

/* File: core/enc_ctrl_pkg.sv */
// constants, types and register map of the encoder control bank
// Operation
// - long vsync set in slave mode: vsync input held 2.5 lines PAL, 3 NTSC
// - long vsync set in master mode: vsync output lasts 3 lines NTSC, 2.5 PAL
// - pedestal bit adds pedestal to NTSC composite; ignored in PAL
// - filter bit set applies separate filter outside active video
// - writing 1 to sleep bit enters low power sleep
// - serial bus registers stay readable and writable during sleep
// - sleep ends when bit written 0 or reset asserted
// - timing bit 0 picks master or slave; bits 2..1 pick timing mode
// - timing bit 3 decides whether blank input is used in slave mode
// - two-bit luma delay field adds 74 ns per step; the code adds one 100 ns clock per step
// - port bit picks 8 or 16 bit pixels; 8-bit uses low pins only
// - timing reset bit written 0, 1, 0 resets timing counters
// - sync shape bits 1..0 hsync width; bits 3..2 hsync to vsync position
// - bits 5..4 hsync to field edge in mode 1, vsync width in mode 2
// - bits 7..6 shift hsync against pixel data in master and slave
// - four bytes form 32-bit subcarrier increment driving phase accumulator
// - lowest subcarrier byte resets to 16h
// - phase register offsets subcarrier phase, 1.41 degrees per bit
// - two even-field and two odd-field caption data byte registers
// - per-line bits remove pedestal in NTSC, enable teletext in PAL
package enc_ctrl_pkg;
  // register subaddresses
  localparam logic [4:0] SUB_POWER = 5'h04;
  localparam logic [4:0] SUB_TIMING = 5'h07;
  localparam logic [4:0] SUB_SYNC = 5'h08;
  localparam logic [4:0] SUB_SUBCARRIER_FREQ_BYTE_0 = 5'h09;
  localparam logic [4:0] SUB_SUBCARRIER_FREQ_BYTE_3 = 5'h0c;
  localparam logic [4:0] SUB_PHASE = 5'h0d;
  localparam logic [4:0] SUB_CAPE0 = 5'h0e;
  localparam logic [4:0] SUB_CAPO0 = 5'h10;
  localparam logic [4:0] SUB_LINE0 = 5'h12;
  localparam logic [4:0] SUB_LAST = 5'h15;
  // bits of the power mode register
  localparam int LONG_VSYNC_BIT = 3;
  localparam int PEDESTAL_BIT = 4;
  localparam int FILTER_BIT = 5;
  localparam int SLEEP_BIT = 6;
  localparam int RESERVED_BIT = 7;
  // bits of the timing register
  localparam int MASTER_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int BLANK_BIT = 3;
  localparam int LUMA_LSB = 4;
  localparam int PORT_BIT = 6;
  localparam int TRESET_BIT = 7;
  // reset values
  localparam logic [7:0] RST_DEFAULT = 8'h00;
  localparam logic [7:0] RST_SUBCARRIER_FREQ_BYTE_0 = 8'h16;
  // vsync length in half lines when long vsync is chosen
  localparam logic [2:0] VS_HALF_PAL = 3'h5;
  localparam logic [2:0] VS_HALF_NTSC = 3'h6;
  // luma delay step, figure in ns and derived clock count
  localparam int CLK_PERIOD_NS = 100;
  localparam int LUMA_STEP_NS = 74;
  localparam int LUMA_STEP_RAW = (LUMA_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] LUMA_STEP_CYC = 2'(LUMA_STEP_RAW < 1 ? 1 : LUMA_STEP_RAW);
  // timing mode codes
  localparam logic [1:0] TMODE_1 = 2'h1;
  localparam logic [1:0] TMODE_2 = 2'h2;
  // serial bus engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_ACK, ST_TX, ST_MACK
  } bus_state_t;
  // sync timing configuration
  typedef struct packed {
    logic master;
    logic [1:0] timing_mode;
    logic blank_use;
    logic [1:0] hsync_width;
    logic [1:0] hsync_to_vsync_offset;
    logic [1:0] field_edge_offset;
    logic [1:0] vsync_width;
    logic [1:0] hsync_pixel_align;
  } sync_cfg_t;
  // per-line blanking masks
  typedef struct packed {
    logic [15:0] even_pedestal_line_mask;
    logic [15:0] odd_pedestal_line_mask;
    logic [15:0] even_teletext_line_mask;
    logic [15:0] odd_teletext_line_mask;
  } line_masks_t;
endpackage : enc_ctrl_pkg

/* File: test/host_bus_model.sv */
// host processor model driving the two-wire serial control bus
module host_bus_model (
  // clock
  input wire logic clk,
  // bus pins, data is open drain
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] dev_addr = 7'h2a; // arbitrary, matches the design default
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one bus clock phase, five system clocks
  task automatic half;
    repeat (5) @(negedge clk);
  endtask : half
  // data moves two clocks after scl falls so no false start or stop is seen
  task automatic clock_bit(input logic drive_low, output logic seen);
    sda_low = drive_low;
    half;
    scl = 1'b1;
    half;
    seen = sda_line;
    scl = 1'b0;
    repeat (2) @(negedge clk);
  endtask : clock_bit
  task automatic start_cond;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b0;
    repeat (2) @(negedge clk);
  endtask : start_cond
  task automatic restart_cond;
    sda_low = 1'b0;
    half;
    scl = 1'b1;
    half;
    start_cond;
  endtask : restart_cond
  task automatic stop_cond;
    sda_low = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask : stop_cond
  // eight bits out or in, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic host_ack, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(~tx[i], s);
      rx[i] = s;
    end
    clock_bit(host_ack, s);
    ack = ~s;
  endtask : xfer
  //////////////////////////////////////////////////////////////////////////
  // n bytes from subaddress sub upward, lowest byte first
  task automatic write_regs(input logic [4:0] sub, input logic [31:0] d, input int n,
                            output logic ok);
    logic [7:0] rx;
    logic a;
    if (sub == enc_ctrl_pkg::SUB_POWER) d[7] = 1'b0;
    start_cond;
    xfer({dev_addr, 1'b0}, 1'b0, rx, ok);
    xfer({3'h0, sub}, 1'b0, rx, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      xfer(d[8*i +: 8], 1'b0, rx, a);
      ok &= a;
    end
    stop_cond;
  endtask : write_regs
  // n bytes read from subaddress sub upward, host acknowledges all but the last
  task automatic read_reg(input logic [4:0] sub, input int n, output logic [31:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic a;
    d = 32'h0;
    start_cond;
    xfer({dev_addr, 1'b0}, 1'b0, rx, ok);
    xfer({3'h0, sub}, 1'b0, rx, a);
    ok &= a;
    restart_cond;
    xfer({dev_addr, 1'b1}, 1'b0, rx, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i < n - 1, rx, a);
      d[8*i +: 8] = rx;
    end
    stop_cond;
  endtask : read_reg
endmodule : host_bus_model

/* File: test/tb.sv */
// self-checking bench of the encoder control bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, pal_mode, scl, host_low, sda_line, sda_out, sda_oe, ok;
  logic long_vs, tcr, ped, filt, sleep;
  logic [15:0] pixel_in, pixel_data, even_cap, odd_cap;
  logic [2:0] vs_half;
  logic [3:0] luma;
  logic [31:0] incr, rdata;
  logic [7:0] phase;
  enc_ctrl_pkg::sync_cfg_t sync_cfg;
  enc_ctrl_pkg::line_masks_t line_masks;
  int n_fail = 0;
  int n_tests = 0;
  int n_pulse = 0;
  // released line is pulled high
  assign sda_line = ~((sda_oe & ~sda_out) | host_low);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  video_encoder_control_regs u_video_encoder_control_regs (.clk(clk), .rst(rst),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .pal_mode(pal_mode), .pixel_in(pixel_in), .pixel_data(pixel_data),
    .sync_cfg(sync_cfg), .long_vsync_select(long_vs), .vsync_half_lines(vs_half),
    .timing_counter_reset(tcr), .luma_delay_cycles(luma), .pedestal_on(ped),
    .blank_filter_on(filt), .sleep(sleep), .subcarrier_increment(incr),
    .subcarrier_phase(phase), .even_caption_data(even_cap), .odd_caption_data(odd_cap),
    .line_masks(line_masks));
  host_bus_model u_host_bus_model (.clk(clk), .scl(scl), .sda_low(host_low),
    .sda_line(sda_line));
  // count timing counter reset pulses
  always @(negedge clk) if (tcr === 1'b1) n_pulse <= n_pulse + 1;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] sub, input logic [31:0] d, input int n);
    u_host_bus_model.write_regs(sub, d, n, ok);
    check(ok, 1'b1, "write ack");
  endtask : wr
  task automatic rd(input logic [4:0] sub, input logic [7:0] exp);
    u_host_bus_model.read_reg(sub, 1, rdata, ok);
    check(ok, 1'b1, "read ack");
    check(rdata, exp, "read data");
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d, failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // watchdog against a hung run
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    pal_mode = 1'b0;
    pixel_in = 16'hbeef;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(incr, 32'h16, "increment reset");
    rd(enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_0, 8'h16);
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h80, 1);
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h00, 1);
    check(n_pulse, 1, "counter reset pulse");
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h00, 1);
    check(n_pulse, 1, "no pulse without a one");
    $display("test reset and counter reset done");
    wr(enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_0, 32'h21f07c1f, 4);
    check(incr, 32'h21f07c1f, "increment");
    rd(enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_3, 8'h21);
    u_host_bus_model.read_reg(enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_0, 4, rdata, ok);
    check({ok, rdata}, {1'b1, 32'h21f07c1f}, "burst read");
    wr(enc_ctrl_pkg::SUB_SUBCARRIER_FREQ_BYTE_0, 32'h0, 4);
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h80, 1);
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h00, 1);
    wr(enc_ctrl_pkg::SUB_PHASE, 32'h40, 1);
    check(phase, 8'h40, "phase offset");
    $display("test subcarrier done");
    wr(enc_ctrl_pkg::SUB_POWER, 32'hb8, 1);
    check({long_vs, vs_half, ped, filt}, {1'b1, 3'h6, 1'b1, 1'b1}, "ntsc power");
    pal_mode = 1'b1;
    @(negedge clk);
    check({vs_half, ped}, {3'h5, 1'b0}, "pal power");
    pal_mode = 1'b0;
    rd(enc_ctrl_pkg::SUB_POWER, 8'h38);
    $display("test mode bits done");
    wr(enc_ctrl_pkg::SUB_POWER, 32'h40, 1);
    check(sleep, 1'b1, "sleep on");
    wr(enc_ctrl_pkg::SUB_CAPE0, 32'h44332211, 4);
    check({even_cap, odd_cap}, 32'h22114433, "captions");
    rd(5'h11, 8'h44);
    wr(enc_ctrl_pkg::SUB_POWER, 32'h00, 1);
    check(sleep, 1'b0, "sleep off by write");
    wr(enc_ctrl_pkg::SUB_POWER, 32'h40, 1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(sleep, 1'b0, "sleep off by reset");
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h80, 1);
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h00, 1);
    check(n_pulse, 3, "pulse after reset");
    $display("test sleep done");
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h08, 1);
    check({sync_cfg.master, sync_cfg.blank_use}, 2'h1, "slave blank");
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h09, 1);
    check({sync_cfg.master, sync_cfg.blank_use}, 2'h2, "master blank");
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h34, 1);
    check(sync_cfg.timing_mode, 2'h2, "timing mode");
    check(luma, 4'(3 * enc_ctrl_pkg::LUMA_STEP_CYC), "luma delay");
    check(pixel_data, 16'h00ef, "narrow port");
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h40, 1);
    check(pixel_data, 16'hbeef, "wide port");
    wr(enc_ctrl_pkg::SUB_SYNC, 32'he4, 1);
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h02, 1);
    check(sync_cfg, 13'b0_01_0_00_01_10_00_11, "mode 1 shape");
    wr(enc_ctrl_pkg::SUB_TIMING, 32'h04, 1);
    check(sync_cfg, 13'b0_10_0_00_01_00_10_11, "mode 2 shape");
    $display("test timing done");
    wr(enc_ctrl_pkg::SUB_LINE0, 32'h87654321, 4);
    check(line_masks, {32'h43218765, 32'h0}, "ntsc lines");
    pal_mode = 1'b1;
    @(negedge clk);
    check(line_masks, {32'h0, 32'h43218765}, "pal lines");
    rd(5'h1f, 8'h00);
    u_host_bus_model.dev_addr = 7'h2b;
    u_host_bus_model.write_regs(enc_ctrl_pkg::SUB_PHASE, 32'h11, 1, ok);
    check(ok, 1'b0, "foreign address refused");
    u_host_bus_model.dev_addr = 7'h2a;
    rd(enc_ctrl_pkg::SUB_PHASE, 8'h00);
    $display("test lines and refusals done");
    wrap_up;
  end
endmodule : tb
